//--- inc/svd_pkg.sv
/*
 * Constants for the supply excursion detector control block: register
 * indices, field positions, reset values and the reference settle time.
 * Assumes a 10 MHz system clock and an 8-bit register port.
 */
package svd_pkg;

    localparam int          ADDR_W            = 2;
    localparam int          DATA_W            = 8;
    localparam int          LEVEL_W           = 4;

    // Register indices on the plain register port
    localparam logic [1:0]  OFS_CONTROL       = 2'h0;
    localparam logic [1:0]  OFS_FLAG2         = 2'h1;
    localparam logic [1:0]  OFS_ENABLE2       = 2'h2;
    localparam logic [1:0]  OFS_INTCTRL       = 2'h3;

    // Control register fields
    localparam int          CTL_DIR_BIT       = 7;
    localparam int          CTL_UNIMP_BIT     = 6;
    localparam int          CTL_STABLE_BIT    = 5;
    localparam int          CTL_ENABLE_BIT    = 4;
    localparam int          CTL_LEVEL_LSB     = 0;

    // Flag, enable and global enable positions
    localparam int          FLAG_BIT          = 2;
    localparam int          IRQ_EN_BIT        = 2;
    localparam int          GLOBAL_EN_BIT     = 7;

    // Reset values
    localparam logic        DIR_RST           = 1'b0;
    localparam logic        ENABLE_RST        = 1'b0;
    localparam logic [3:0]  LEVEL_RST         = 4'h5;
    localparam logic        FLAG_RST          = 1'b0;
    localparam logic        IRQ_EN_RST        = 1'b0;
    localparam logic        GLOBAL_EN_RST     = 1'b0;

    // Trip level code that routes the external input to the comparator
    localparam logic [3:0]  LEVEL_EXTERNAL    = 4'hF;

    // Reference settle time, rounded up to whole clock cycles
    localparam int          CLK_PERIOD_NS     = 100;
    localparam int          SETTLE_TIME_NS    = 20000;
    localparam int          SETTLE_CYCLES     =
        (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SETTLE_CNT_W      = 12;

    typedef enum logic [2:0] {
        SVD_OFF    = 3'b001,
        SVD_SETTLE = 3'b010,
        SVD_ARMED  = 3'b100
    } svd_state_t;

endpackage

//--- hdl/svd_settle_timer.sv
/*
 * Reference settle timer: counts clock cycles while run is high and
 * holds done once the count is reached. Clearing run restarts it.
 * Assumes run is synchronous to clk.
 */
`timescale 1ns/10ps
module svd_settle_timer #(
    parameter int CYCLES = svd_pkg::SETTLE_CYCLES,
    parameter int CNT_W  = svd_pkg::SETTLE_CNT_W
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      done
);
    import svd_pkg::*;

    localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES);

    logic [CNT_W-1:0] cnt_reg;

    // Restart on every enable, so each enable waits the full time
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (!run) begin
            cnt_reg <= '0;
        end else if (cnt_reg != LAST) begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

    assign done = run && (cnt_reg == LAST);

endmodule // svd_settle_timer

//--- hdl/svd_detect_ctrl.sv
/*
 * Control and flag logic of the supply excursion detector: control
 * register, reference settle sequencing, sticky detect flag, interrupt
 * gating and wake from sleep.
 * Assumes the analog comparator result arrives synchronous to clk.
 */
`timescale 1ns/10ps
module svd_detect_ctrl #(
    parameter int SETTLE_CYCLES = svd_pkg::SETTLE_CYCLES
) (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [svd_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [svd_pkg::DATA_W-1:0]  reg_wdata,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    output logic      [svd_pkg::DATA_W-1:0]  reg_rdata,
    input  wire logic                        internal_supply_high,
    input  wire logic                        external_supply_high,
    input  wire logic                        sleep_mode,
    output logic                             detector_power,
    output logic                             external_select,
    output logic      [svd_pkg::LEVEL_W-1:0] trip_level,
    output logic                             irq,
    output logic                             wake_req,
    output logic                             wake_to_vector
);
    import svd_pkg::*;

    logic                direction_select_reg;
    logic                detect_enable_reg;
    logic [LEVEL_W-1:0]  trip_level_reg;
    logic                detect_flag_reg;
    logic                detect_flag_next;
    logic                detect_irq_enable_reg;
    logic                global_irq_enable_reg;
    logic [DATA_W-1:0]   rdata_reg;
    logic [DATA_W-1:0]   rdata_next;
    svd_state_t          state_reg;
    svd_state_t          state_next;
    logic                settle_done;
    logic                reference_stable;
    logic                supply_high;
    logic                trip_now;
    logic                flag_set;
    logic                wr_control;
    logic                wr_flag;

    assign wr_control = reg_wr && (reg_addr == OFS_CONTROL);
    assign wr_flag    = reg_wr && (reg_addr == OFS_FLAG2);

    // Control register; stable and bit 6 have no storage to write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            direction_select_reg <= DIR_RST;
            detect_enable_reg    <= ENABLE_RST;
            trip_level_reg       <= LEVEL_RST;
        end else if (wr_control) begin
            direction_select_reg <= reg_wdata[CTL_DIR_BIT];
            detect_enable_reg    <= reg_wdata[CTL_ENABLE_BIT];
            trip_level_reg       <=
                reg_wdata[CTL_LEVEL_LSB +: LEVEL_W];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            detect_irq_enable_reg <= IRQ_EN_RST;
        end else if (reg_wr && (reg_addr == OFS_ENABLE2)) begin
            detect_irq_enable_reg <= reg_wdata[IRQ_EN_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            global_irq_enable_reg <= GLOBAL_EN_RST;
        end else if (reg_wr && (reg_addr == OFS_INTCTRL)) begin
            global_irq_enable_reg <= reg_wdata[GLOBAL_EN_BIT];
        end
    end

    // Timer restarts from zero on each enable
    svd_settle_timer #(
        .CYCLES (SETTLE_CYCLES),
        .CNT_W  (SETTLE_CNT_W)
    ) u_settle (
        .clk  (clk),
        .rst  (rst),
        .run  (detect_enable_reg),
        .done (settle_done)
    );

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SVD_OFF: begin
                if (detect_enable_reg) begin
                    state_next = SVD_SETTLE;
                end
            end
            SVD_SETTLE: begin
                if (!detect_enable_reg) begin
                    state_next = SVD_OFF;
                end else if (settle_done) begin
                    state_next = SVD_ARMED;
                end
            end
            SVD_ARMED: begin
                if (!detect_enable_reg) begin
                    state_next = SVD_OFF;
                end
            end
            default: begin
                state_next = SVD_OFF;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= SVD_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reference_stable = (state_reg == SVD_ARMED);

    // Comparator source and direction
    assign external_select = (trip_level_reg == LEVEL_EXTERNAL);
    assign supply_high     = external_select ? external_supply_high
                                             : internal_supply_high;
    assign trip_now        = direction_select_reg ? supply_high
                                                  : !supply_high;
    // Settle interval masks crossings; short excursions can be missed
    assign flag_set = reference_stable && trip_now;

    // Hardware set beats a software clear in the same cycle
    always_comb begin
        detect_flag_next = detect_flag_reg;
        if (wr_flag) begin
            detect_flag_next = reg_wdata[FLAG_BIT];
        end
        if (flag_set) begin
            detect_flag_next = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            detect_flag_reg <= FLAG_RST;
        end else begin
            detect_flag_reg <= detect_flag_next;
        end
    end

    // Read data valid only in the cycle after the read strobe
    always_comb begin
        rdata_next = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_CONTROL: begin
                    rdata_next[CTL_DIR_BIT]    = direction_select_reg;
                    rdata_next[CTL_UNIMP_BIT]  = 1'b0;
                    rdata_next[CTL_STABLE_BIT] = reference_stable;
                    rdata_next[CTL_ENABLE_BIT] = detect_enable_reg;
                    rdata_next[CTL_LEVEL_LSB +: LEVEL_W] = trip_level_reg;
                end
                OFS_FLAG2: begin
                    rdata_next[FLAG_BIT] = detect_flag_reg;
                end
                OFS_ENABLE2: begin
                    rdata_next[IRQ_EN_BIT] = detect_irq_enable_reg;
                end
                OFS_INTCTRL: begin
                    rdata_next[GLOBAL_EN_BIT] = global_irq_enable_reg;
                end
                default: begin
                    rdata_next = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata      = rdata_reg;
    assign detector_power = detect_enable_reg;
    assign trip_level     = trip_level_reg;
    assign irq            = detect_flag_reg && detect_irq_enable_reg
                            && global_irq_enable_reg;
    // Sleep does not stop the detector; any set flag wakes
    assign wake_req       = sleep_mode && detect_flag_reg;
    assign wake_to_vector = wake_req && global_irq_enable_reg;

    // Helper: cycles since the enable came on, saturating
    logic [SETTLE_CNT_W:0] en_age;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_age <= '0;
        end else if (!detect_enable_reg) begin
            en_age <= '0;
        end else if (!en_age[SETTLE_CNT_W]) begin
            en_age <= en_age + (SETTLE_CNT_W+1)'(1);
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    AST_DIR_FALL: assert property (
        reference_stable && !direction_select_reg && !supply_high
        |=> detect_flag_reg)
        else $error("Fall below trip did not set flag");
    AST_DIR_RISE: assert property (
        reference_stable && direction_select_reg && supply_high
        |=> detect_flag_reg)
        else $error("Rise above trip did not set flag");
    AST_ENABLE_WRITE: assert property (
        wr_control |=> detector_power == $past(reg_wdata[CTL_ENABLE_BIT]))
        else $error("Enable bit did not follow write");
    AST_STABLE_RO: assert property (
        wr_control && !reference_stable && !settle_done
        |=> !reference_stable)
        else $error("Stable status changed by write");
    AST_NO_EARLY_FLAG: assert property (
        !reference_stable && !wr_flag && !detect_flag_reg
        |=> !detect_flag_reg)
        else $error("Flag set before reference stable");
    AST_SETTLE_TIME: assert property (
        $rose(reference_stable)
        |-> en_age == (SETTLE_CNT_W+1)'(SETTLE_CYCLES + 1))
        else $error("Stable rose at wrong settle count");
    AST_EXT_SELECT: assert property (
        external_select == (trip_level == LEVEL_EXTERNAL))
        else $error("External select wrong for level code");
    AST_SET_WINS: assert property (
        flag_set && wr_flag |=> detect_flag_reg)
        else $error("Software clear beat hardware set");
    AST_IRQ_GATE: assert property (
        irq |-> detect_flag_reg && detect_irq_enable_reg
                && global_irq_enable_reg)
        else $error("Interrupt without all enables");
    AST_WAKE: assert property (
        sleep_mode && flag_set ##1 sleep_mode |-> wake_req)
        else $error("No wake from sleep on crossing");
    AST_VECTOR: assert property (
        wake_to_vector |-> global_irq_enable_reg)
        else $error("Vector taken without global enable");
    AST_DISABLE_CLEARS: assert property (
        !detect_enable_reg |=> !reference_stable)
        else $error("Stable held while disabled");
    AST_UNIMP_ZERO: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_CONTROL
        |-> !reg_rdata[CTL_UNIMP_BIT])
        else $error("Bit 6 read as one");

    // Register writes land whole; status only moves by hardware
    AST_STABLE_KEEP: assert property (
        wr_control && reference_stable && detect_enable_reg
        && reg_wdata[CTL_ENABLE_BIT] |=> reference_stable)
        else $error("Stable status cleared by write");
    AST_LEVEL_WRITE: assert property (
        wr_control
        |=> trip_level == $past(reg_wdata[CTL_LEVEL_LSB +: LEVEL_W]))
        else $error("Trip level did not follow write");
    AST_DIR_WRITE: assert property (
        wr_control
        |=> direction_select_reg == $past(reg_wdata[CTL_DIR_BIT]))
        else $error("Direction did not follow write");
    AST_RDATA_STABLE: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_CONTROL
        |-> reg_rdata[CTL_STABLE_BIT] == $past(reference_stable))
        else $error("Stable status read back wrong");
    AST_FLAG_READ: assert property (
        $past(reg_rd) && $past(reg_addr) == OFS_FLAG2
        |-> reg_rdata[FLAG_BIT] == $past(detect_flag_reg))
        else $error("Flag read back wrong");

    // Comparator source and direction; the wrong edge must stay quiet
    AST_EXT_SOURCE: assert property (
        reference_stable && external_select && direction_select_reg
        && external_supply_high |=> detect_flag_reg)
        else $error("External input crossing missed");
    AST_INT_SOURCE: assert property (
        reference_stable && !external_select && direction_select_reg
        && internal_supply_high |=> detect_flag_reg)
        else $error("Internal tap crossing missed");
    AST_FALL_ONLY: assert property (
        !direction_select_reg && supply_high && !wr_flag
        && !detect_flag_reg |=> !detect_flag_reg)
        else $error("Fall detector fired on high supply");
    AST_RISE_ONLY: assert property (
        direction_select_reg && !supply_high && !wr_flag
        && !detect_flag_reg |=> !detect_flag_reg)
        else $error("Rise detector fired on low supply");
    AST_SETTLE_MASK: assert property (
        en_age <= (SETTLE_CNT_W+1)'(SETTLE_CYCLES)
        |-> !reference_stable)
        else $error("Stable before settle interval ended");

    // Flag keeps its value until software clears it
    AST_FLAG_HOLD: assert property (
        detect_flag_reg && !wr_flag |=> detect_flag_reg)
        else $error("Flag dropped without a clear");
    AST_SW_CLEAR: assert property (
        wr_flag && !reg_wdata[FLAG_BIT] && !flag_set
        |=> !detect_flag_reg)
        else $error("Software clear of flag lost");
    AST_IRQ_FLAG: assert property (
        detect_flag_reg && detect_irq_enable_reg && global_irq_enable_reg
        |-> irq)
        else $error("Interrupt missing with all enables");
    AST_WAKE_OFF: assert property (
        !sleep_mode |-> !wake_req)
        else $error("Wake request while awake");

    COV_ARMED: cover property ($rose(reference_stable));
    COV_FLAG: cover property ($rose(detect_flag_reg) && reference_stable);
    COV_WAKE: cover property ($rose(wake_to_vector));
    COV_RESET_FLAG: cover property (flag_set && wr_flag);
    COV_EXTERNAL: cover property (external_select && flag_set);

endmodule // svd_detect_ctrl

//--- verif/tb.sv
/*
 * Self-checking bench for the supply excursion detector control block.
 * Assumes svd_pkg is compiled first; settle count is shortened to 4.
 */
`timescale 1ns/10ps
module tb;
    import svd_pkg::*;

    localparam int SETTLE  = 4;
    localparam int CEILING = 3000;

    logic                clk;
    logic                rst;
    logic [ADDR_W-1:0]   reg_addr;
    logic [DATA_W-1:0]   reg_wdata;
    logic                reg_wr;
    logic                reg_rd;
    logic [DATA_W-1:0]   reg_rdata;
    logic                internal_supply_high;
    logic                external_supply_high;
    logic                sleep_mode;
    logic                detector_power;
    logic                external_select;
    logic [LEVEL_W-1:0]  trip_level;
    logic                irq;
    logic                wake_req;
    logic                wake_to_vector;
    int                  fails;
    int                  num_checks;
    int                  cycles = 0;

    svd_detect_ctrl #(.SETTLE_CYCLES(SETTLE)) dut (
        .clk                  (clk),
        .rst                  (rst),
        .reg_addr             (reg_addr),
        .reg_wdata            (reg_wdata),
        .reg_wr               (reg_wr),
        .reg_rd               (reg_rd),
        .reg_rdata            (reg_rdata),
        .internal_supply_high (internal_supply_high),
        .external_supply_high (external_supply_high),
        .sleep_mode           (sleep_mode),
        .detector_power       (detector_power),
        .external_select      (external_select),
        .trip_level           (trip_level),
        .irq                  (irq),
        .wake_req             (wake_req),
        .wake_to_vector       (wake_to_vector)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] a, input logic [7:0] e,
                      input string n);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        chk8(n, e, reg_rdata);
    endtask

    task automatic sup(input logic i, input logic e);
        @(posedge clk);
        internal_supply_high <= i;
        external_supply_high <= e;
    endtask

    // Bounded wait, twice the settle count plus four cycles of margin
    task automatic wait_irq;
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 2 * SETTLE + 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk1("irq", 1'b1, irq);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == CEILING) begin
            fails++;
            $display("ERROR timeout expected %0d seen %0d", CEILING, cycles);
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        internal_supply_high = 1'b1;
        external_supply_high = 1'b1;
        sleep_mode = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk1("detector_power", 1'b0, detector_power);
        rd(OFS_CONTROL, 8'h05, "control");
        rd(OFS_FLAG2, 8'h00, "flag2");
        rd(OFS_ENABLE2, 8'h00, "enable2");
        rd(OFS_INTCTRL, 8'h00, "intctrl");
        $display("test reset done");
        // Status and unused bits must ignore writes
        wr(OFS_CONTROL, 8'hFF);
        #1;
        chk1("detector_power", 1'b1, detector_power);
        rd(OFS_CONTROL, 8'h9F, "control");
        wr(OFS_CONTROL, 8'h00);
        #1;
        chk1("detector_power", 1'b0, detector_power);
        for (int c = 0; c < 16; c++) begin
            wr(OFS_CONTROL, {4'h0, c[3:0]});
            #1;
            chk8("trip_level", {4'h0, c[3:0]}, {4'h0, trip_level});
            chk1("external_select", c == 15, external_select);
        end
        $display("test fields done");
        // Low supply already present before enable
        wr(OFS_ENABLE2, 8'h04);
        wr(OFS_INTCTRL, 8'h80);
        sup(1'b0, 1'b1);
        wr(OFS_CONTROL, 8'h15);
        repeat (SETTLE) begin
            @(posedge clk);
            #1;
            chk1("irq", 1'b0, irq);
        end
        wait_irq();
        rd(OFS_CONTROL, 8'h35, "control");
        rd(OFS_FLAG2, 8'h04, "flag2");
        wr(OFS_FLAG2, 8'h00);
        rd(OFS_FLAG2, 8'h04, "flag2");
        sup(1'b1, 1'b1);
        wr(OFS_FLAG2, 8'h00);
        rd(OFS_FLAG2, 8'h00, "flag2");
        chk1("irq", 1'b0, irq);
        wr(OFS_CONTROL, 8'h95);
        wait_irq();
        $display("test detect done");
        // Crossing while asleep
        @(posedge clk);
        sleep_mode <= 1'b1;
        sup(1'b0, 1'b1);
        wr(OFS_FLAG2, 8'h00);
        #1;
        chk1("wake_req", 1'b0, wake_req);
        sup(1'b1, 1'b1);
        repeat (2) @(posedge clk);
        #1;
        chk1("wake_req", 1'b1, wake_req);
        chk1("wake_to_vector", 1'b1, wake_to_vector);
        wr(OFS_INTCTRL, 8'h00);
        #1;
        chk1("wake_to_vector", 1'b0, wake_to_vector);
        chk1("irq", 1'b0, irq);
        wr(OFS_ENABLE2, 8'h00);
        wr(OFS_INTCTRL, 8'h80);
        #1;
        chk1("irq", 1'b0, irq);
        chk1("wake_req", 1'b1, wake_req);
        @(posedge clk);
        sleep_mode <= 1'b0;
        $display("test sleep done");
        // External pin only, internal comparator held quiet
        sup(1'b0, 1'b0);
        wr(OFS_CONTROL, 8'h0F);
        wr(OFS_CONTROL, 8'h8F);
        wr(OFS_CONTROL, 8'h9F);
        wr(OFS_FLAG2, 8'h00);
        rd(OFS_FLAG2, 8'h00, "flag2");
        sup(1'b0, 1'b1);
        repeat (2) @(posedge clk);
        rd(OFS_FLAG2, 8'h04, "flag2");
        wr(OFS_CONTROL, 8'h05);
        rd(OFS_CONTROL, 8'h05, "control");
        $display("test external done");
        wr(OFS_CONTROL, 8'h9A);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk1("detector_power", 1'b0, detector_power);
        chk1("external_select", 1'b0, external_select);
        rd(OFS_CONTROL, 8'h05, "control");
        rd(OFS_FLAG2, 8'h00, "flag2");
        $display("test second reset done");
        summarize();
    end
endmodule // tb
